// ===== rtl/lit_xcvr.sv
// Byte-wide full-duplex link transceiver: sender serializer, cable
// receiver with timing and operating states, local receiver deserializer.
// Assumes link clocks arrive as plain pins sampled by ref_clk.
`timescale 1ns/1ps
module lit_xcvr
    import lit_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst,
    // Word input from the local chip.
    input wire lit_pkg::lit_flit_t tx_flit,
    input wire logic tx_valid,
    output logic tx_ready,
    // Cable side transmit lines and forwarded clock.
    output logic [lit_pkg::LIT_SYM_W-1:0] cab_tx_data,
    output logic cab_tx_clk,
    // Cable side receive lines and clock.
    input wire logic [lit_pkg::LIT_SYM_W-1:0] cab_rx_data,
    input wire logic cab_rx_clk,
    // Local side transmit lines toward the local chip.
    output logic [lit_pkg::LIT_SYM_W-1:0] loc_tx_data,
    output logic loc_tx_clk,
    output logic loc_tx_valid,
    // Local side receive lines and forwarded clock.
    input wire logic [lit_pkg::LIT_SYM_W-1:0] loc_rx_data,
    input wire logic loc_rx_clk,
    // Deserialized flit output.
    output lit_pkg::lit_flit_t rx_flit,
    output logic rx_valid,
    input wire logic rx_ready,
    // Cable receiver status.
    output logic cab_operating
);
    import lit_pkg::*;

    // ---- Sender: buffer, then serializer. ----
    logic [LIT_FLIT_W-1:0] sb_data;
    logic sb_valid;
    logic sb_ready;
    logic [1:0] ser_idx;
    logic ser_busy;
    lit_flit_t ser_word;
    logic [1:0] ser_lat;

    lit_buf2 #(.WIDTH(LIT_FLIT_W)) u_tx_buf (
        .ref_clk(ref_clk),
        .rst(rst),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .in_data(tx_flit),
        .out_valid(sb_valid),
        .out_ready(sb_ready),
        .out_data(sb_data)
    );

    // A new word is taken when the serializer is idle or as the last byte of the old one leaves.
    wire ser_last = ser_busy && (ser_idx == 2'h3);
    assign sb_ready = !ser_busy || ser_last;
    wire ser_take = sb_valid && sb_ready;

    // Serializer: two cycles of pipeline plus the output flop make
    // three cycles from acceptance to the first byte on the line.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ser_busy <= 1'b0;
            ser_idx <= 2'h0;
            ser_word <= '0;
            ser_lat <= 2'h0;
        end else if (ser_take) begin
            ser_busy <= 1'b1;
            ser_word <= lit_flit_t'(sb_data);
            ser_idx <= 2'h0;
            ser_lat <= 2'(LIT_SER_LAT - 2);
        end else if (ser_lat != 2'h0) begin
            ser_lat <= ser_lat - 2'h1;
        end else if (ser_busy) begin
            ser_idx <= ser_idx + 2'h1;
            ser_busy <= !ser_last;
        end
    end

    wire ser_emit = ser_busy && (ser_lat == 2'h0);

    // Line driver flop; idle sends the training symbol.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cab_tx_data <= LIT_TRAIN_SYM;
            cab_tx_clk <= 1'b0;
        end else begin
            cab_tx_data <= ser_emit ? ser_word.data[ser_idx]
                                    : LIT_TRAIN_SYM;
            cab_tx_clk <= ~cab_tx_clk;
        end
    end

    // ---- Cable receiver. ----
    // Two-flop synchronizers on every cable line and its clock.
    logic [LIT_SYM_W:0] crx_s1;
    logic [LIT_SYM_W:0] crx_s2;
    logic crx_clk_d;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            crx_s1 <= '0;
            crx_s2 <= '0;
            crx_clk_d <= 1'b0;
        end else begin
            crx_s1 <= {cab_rx_clk, cab_rx_data};
            crx_s2 <= crx_s1;
            crx_clk_d <= crx_s2[LIT_SYM_W];
        end
    end
    wire crx_edge = crx_s2[LIT_SYM_W] ^ crx_clk_d;

    // Per-line history and delay select: up to three symbols of skew.
    logic [LIT_SYM_W-1:0][LIT_SKEW_MAX:0] line_hist;
    logic [LIT_SYM_W-1:0][1:0] line_dly;
    logic [LIT_SYM_W-1:0] line_ok;
    logic [LIT_SYM_W-1:0] aligned;
    logic [LIT_SYM_W-1:0] lone_miss;
    lit_rx_state_t crx_state;
    logic [4:0] align_cnt;
    logic [LIT_SYM_W-1:0] train_bits;
    assign train_bits = LIT_TRAIN_SYM;

    genvar gl;
    generate
        for (gl = 0; gl < LIT_SYM_W; gl++) begin : g_line
            assign aligned[gl] = line_hist[gl][line_dly[gl]];
            assign line_ok[gl] = aligned[gl] == train_bits[gl];
            // Outside timing, only a line that alone misses an idle symbol
            // is trimmed, so data words do not walk the taps. A data word
            // one bit away from idle still looks like drift: a limitation.
            assign lone_miss[gl] = !line_ok[gl] &&
                                   (&(line_ok | (LIT_SYM_W'(1) << gl)));
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    line_hist[gl] <= '0;
                    line_dly[gl] <= 2'h0;
                end else if (crx_edge) begin
                    line_hist[gl] <= {line_hist[gl][LIT_SKEW_MAX-1:0],
                                      crx_s2[gl]};
                    // One step on any miss in timing, one-step trim on a lone miss in operating.
                    if (!line_ok[gl] && crx_state == LIT_TIMING) begin
                        line_dly[gl] <= line_dly[gl] + 2'h1;
                    end else if (lone_miss[gl]) begin
                        line_dly[gl] <= line_dly[gl] + 2'h1;
                    end
                end
            end
        end
    endgenerate

    // State machine: leave timing after a run of aligned training symbols.
    // The operating state never falls back; drift is only trimmed.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            crx_state <= LIT_TIMING;
            align_cnt <= 5'h0;
        end else if (crx_edge) begin
            unique case (crx_state)
                LIT_TIMING: begin
                    if (&line_ok) begin
                        align_cnt <= align_cnt + 5'h1;
                    end else begin
                        align_cnt <= 5'h0;
                    end
                    if (align_cnt == 5'(LIT_ALIGN_CYC - 1)) begin
                        crx_state <= LIT_OPERATING;
                        align_cnt <= 5'h0;
                    end
                end
                LIT_OPERATING: begin
                    align_cnt <= 5'h0;
                end
            endcase
        end
    end

    // Latency pipe: sync, edge detect, history and the tick take four
    // cycles, this four more. The tick waits until the history holds the
    // symbol that raised it, so a zero-tap line passes the newest symbol.
    localparam int PIPE_N = LIT_RX_LAT - 4;
    logic [PIPE_N-1:0][LIT_SYM_W:0] crx_pipe;
    logic crx_tick;
    wire crx_new = crx_edge && (crx_state == LIT_OPERATING);
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            crx_tick <= 1'b0;
            crx_pipe <= '0;
        end else begin
            crx_tick <= crx_new;
            crx_pipe <= {crx_pipe[PIPE_N-2:0], {crx_tick, aligned}};
        end
    end

    // Local transmit flops: invalid until operating. The forwarded clock
    // toggles with each symbol passed, so the local chip can sample on it.
    wire loc_sym = crx_pipe[PIPE_N-1][LIT_SYM_W] &&
                   (crx_state == LIT_OPERATING);
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            loc_tx_data <= '0;
            loc_tx_valid <= 1'b0;
            loc_tx_clk <= 1'b0;
            cab_operating <= 1'b0;
        end else begin
            loc_tx_data <= crx_pipe[PIPE_N-1][LIT_SYM_W-1:0];
            loc_tx_valid <= loc_sym;
            loc_tx_clk <= loc_tx_clk ^ loc_sym;
            cab_operating <= (crx_state == LIT_OPERATING);
        end
    end

    // ---- Local receiver. ----
    logic [LIT_SYM_W:0] lrx_s1;
    logic [LIT_SYM_W:0] lrx_s2;
    logic [LIT_SYM_W-1:0] lrx_s3;
    logic lrx_clk_d;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lrx_s1 <= '0;
            lrx_s2 <= '0;
            lrx_s3 <= '0;
            lrx_clk_d <= 1'b0;
        end else begin
            lrx_s1 <= {loc_rx_clk, loc_rx_data};
            lrx_s2 <= lrx_s1;
            lrx_s3 <= lrx_s2[LIT_SYM_W-1:0];
            lrx_clk_d <= lrx_s2[LIT_SYM_W];
        end
    end
    // Data is taken from the same sample that showed the clock edge; lrx_s3 delays it to meet lrx_take.
    wire lrx_edge = lrx_s2[LIT_SYM_W] ^ lrx_clk_d;
    logic lrx_take;
    logic [1:0] lrx_idx;
    lit_flit_t lrx_word;
    logic rb_valid;
    logic [LIT_FLIT_W-1:0] rb_data;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lrx_take <= 1'b0;
            lrx_idx <= 2'h0;
            lrx_word <= '0;
            rb_valid <= 1'b0;
        end else begin
            lrx_take <= lrx_edge;
            rb_valid <= 1'b0;
            if (lrx_take) begin
                lrx_word.data[lrx_idx] <= lrx_s3;
                lrx_idx <= lrx_idx + 2'h1;
                rb_valid <= (lrx_idx == 2'h3);
            end
        end
    end
    // The buffer write lags one cycle so the fourth byte is included.
    assign rb_data = lrx_word;

    logic [LIT_FLIT_W-1:0] rx_out;
    logic rx_out_valid;
    lit_buf2 #(.WIDTH(LIT_FLIT_W)) u_rx_buf (
        .ref_clk(ref_clk),
        .rst(rst),
        .in_valid(rb_valid),
        .in_ready(),
        .in_data(rb_data),
        .out_valid(rx_out_valid),
        .out_ready(rx_ready),
        .out_data(rx_out)
    );
    // With no backward path on the local lines a full buffer drops flits;
    // two entries absorb a short receiver stall.
    assign rx_flit = lit_flit_t'(rx_out);
    assign rx_valid = rx_out_valid;
endmodule

// ===== rtl/lit_pkg.sv
// Package for the link transceiver: symbol layout, flit type and timing.
// Assumes a single core clock of 100 MHz; LIT_SYM_CYC derives from it.
package lit_pkg;
    localparam int LIT_SYM_W = 9;
    localparam int LIT_BYTES = 4;
    localparam int LIT_FLIT_W = LIT_SYM_W * LIT_BYTES;
    localparam int LIT_CLK_PS = 10000;
    localparam int LIT_DATA_PERIOD_PS = 2000;
    localparam int LIT_WORD_PERIOD_PS = 8000;
    // Symbol periods fold to at least one core cycle.
    localparam int LIT_SYM_CYC = (LIT_DATA_PERIOD_PS >= LIT_CLK_PS) ?
        LIT_DATA_PERIOD_PS / LIT_CLK_PS : 1;
    localparam int LIT_SER_LAT = 3;
    localparam int LIT_RX_LAT = 8;
    localparam int LIT_SKEW_MAX = 3;
    localparam int LIT_ALIGN_CYC = 16;
    localparam logic [8:0] LIT_TRAIN_SYM = 9'h1BC;
    localparam logic [1:0] LIT_SYNC_RST = 2'h0;

    typedef struct packed {
        logic [LIT_SYM_W-1:0] sym;
        logic valid;
    } lit_sym_t;

    typedef struct packed {
        logic [LIT_BYTES-1:0][LIT_SYM_W-1:0] data;
    } lit_flit_t;

    typedef enum logic [1:0] {
        LIT_TIMING,
        LIT_OPERATING
    } lit_rx_state_t;
endpackage

// ===== rtl/lit_buf2.sv
// Two-entry valid/ready buffer.
// Assumes both sides run on the core clock.
`timescale 1ns/1ps
module lit_buf2 #(
    parameter int WIDTH = 36
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst,
    // Filling side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [1:0][WIDTH-1:0] mem;
    logic rd_ptr;
    logic wr_ptr;
    logic [1:0] count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    // Full and empty come straight from the occupancy count.
    assign in_ready = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data = mem[rd_ptr];

    // Pointer and count update.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end

    // Storage is written without reset; the count guards its reads.
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule

// ===== tb/lit_xcvr_chk.sv
// Port checker for the link transceiver, bound into every instance.
// Assumes it sees only the top ports; pins are sampled on ref_clk.
`timescale 1ns/1ps
module lit_chk (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst,
    // Watched ports.
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic cab_tx_clk,
    input wire logic [lit_pkg::LIT_SYM_W-1:0] cab_rx_data,
    input wire logic cab_rx_clk,
    input wire logic loc_tx_valid,
    input wire lit_pkg::lit_flit_t rx_flit,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic cab_operating
);
    import lit_pkg::*;
    logic clk_q;
    logic [4:0] n_train;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Counts training edges at the pins. The aligner sees them later, so
    // this count can only run ahead of the design's own.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            clk_q <= 1'b0;
            n_train <= 5'h00;
        end else begin
            clk_q <= cab_rx_clk;
            if (cab_rx_data != LIT_TRAIN_SYM)
                n_train <= 5'h00;
            else if (clk_q != cab_rx_clk && n_train != 5'h1F)
                n_train <= n_train + 5'h01;
        end
    end
    chk_out_gated: assert property (!cab_operating |-> !loc_tx_valid)
        else $error("symbol passed before operating state");
    chk_op_sticky: assert property (cab_operating |=> cab_operating)
        else $error("operating state was left");
    chk_align_done: assert property (
        $rose(cab_operating) |-> n_train >= LIT_ALIGN_CYC)
        else $error("operating state entered before alignment");
    chk_clk_fwd: assert property (
        1'b1 |=> cab_tx_clk != $past(cab_tx_clk))
        else $error("forwarded clock missed a toggle");
    chk_sym_pulse: assert property (loc_tx_valid |=> !loc_tx_valid)
        else $error("symbol strobe longer than one cycle");
    chk_rx_lat: assert property (
        cab_operating && clk_q != cab_rx_clk |-> ##[7:9] loc_tx_valid)
        else $error("cable symbol not passed in time");
    chk_flit_hold: assert property (
        rx_valid && !rx_ready |=> rx_valid && $stable(rx_flit))
        else $error("stalled flit changed or vanished");
    chk_ready_fall: assert property (
        $fell(tx_ready) |-> $past(tx_valid))
        else $error("ready dropped without a word offered");
endmodule
bind lit_xcvr lit_chk u_chk (.ref_clk, .rst, .tx_valid, .tx_ready,
    .cab_tx_clk, .cab_rx_data, .cab_rx_clk, .loc_tx_valid, .rx_flit,
    .rx_valid, .rx_ready, .cab_operating);

// ===== tb/lit_peer.sv
// Far side: a peer transceiver on the cable pins and a local sender on
// the local pins. Assumes go rises after reset; link period is 125 ns.
`timescale 1ns/1ps
module lit_peer (
    // Start request from the bench.
    input wire logic go,
    // Cable receive pins of the device.
    output logic [lit_pkg::LIT_SYM_W-1:0] cab_rx_data,
    output logic cab_rx_clk,
    // Local receive pins of the device.
    output logic [lit_pkg::LIT_SYM_W-1:0] loc_rx_data,
    output logic loc_rx_clk
);
    import lit_pkg::*;
    // Training, then four data symbols. Data leads each clock edge by
    // 10 ns and holds 52.5 ns; afterwards the clock stands still and the
    // data flips, so a stale sample can never pass for a good one.
    initial begin
        cab_rx_data = LIT_TRAIN_SYM;
        cab_rx_clk = 1'b0;
        wait (go);
        for (int i = 0; i < 28; i++) begin
            cab_rx_data = (i < 24) ? LIT_TRAIN_SYM : 9'h0A0 + 9'(i);
            #10 cab_rx_clk = ~cab_rx_clk;
            #52.5;
        end
        forever #10 cab_rx_data = ~cab_rx_data;
    end
    // Eight symbols for the local receiver, two flits' worth.
    initial begin
        loc_rx_data = 9'h000;
        loc_rx_clk = 1'b0;
        wait (go);
        for (int j = 0; j < 8; j++) begin
            loc_rx_data = 9'h101 + 9'(j);
            #10 loc_rx_clk = ~loc_rx_clk;
            #52.5;
        end
        forever #10 loc_rx_data = ~loc_rx_data;
    end
endmodule

// ===== tb/lit_xcvr_bench.sv
// Self-checking bench for the link transceiver; lit_peer plays the far
// side. Assumes the checker is bound in from its own file.
`timescale 1ns/1ps
module lit_xcvr_bench;
    import lit_pkg::*;
    typedef struct {
        lit_flit_t flit;
        logic [LIT_SYM_W-1:0] first;
    } lit_row_t;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic tx_valid = 1'b0;
    logic rx_ready = 1'b0;
    logic go = 1'b0;
    logic full_seen = 1'b0;
    logic tx_ready, cab_rx_clk, loc_rx_clk, loc_tx_valid, rx_valid;
    logic loc_tx_clk;
    logic loc_clk_q = 1'b0;
    int n_loc_clk = 0;
    logic [LIT_SYM_W-1:0] exp_sym;
    logic cab_operating;
    logic [LIT_SYM_W-1:0] cab_tx_data, cab_rx_data, loc_tx_data;
    logic [LIT_SYM_W-1:0] loc_rx_data;
    lit_flit_t tx_flit = '0;
    lit_flit_t rx_flit;
    int cyc = 0;
    int t_take;
    int failures = 0;
    int n_compared = 0;
    logic [LIT_SYM_W-1:0] txq [$];
    logic [LIT_SYM_W-1:0] locq [$];
    int txt [$];
    lit_flit_t flq [$];
    // Sym0 is bits 8:0 and goes first; 0x1BC is avoided, being idle.
    lit_row_t rows [4] = '{
        '{{9'h004, 9'h003, 9'h002, 9'h001}, 9'h001},
        '{{9'h1FF, 9'h000, 9'h1FF, 9'h000}, 9'h000},
        '{{9'h1BD, 9'h1BB, 9'h0FF, 9'h100}, 9'h100},
        '{{9'h055, 9'h0AA, 9'h155, 9'h0AA}, 9'h0AA}};
    lit_xcvr dut (.ref_clk, .rst, .tx_flit, .tx_valid, .tx_ready,
        .cab_tx_data, .cab_tx_clk(), .cab_rx_data, .cab_rx_clk,
        .loc_tx_data, .loc_tx_clk, .loc_tx_valid, .loc_rx_data,
        .loc_rx_clk, .rx_flit, .rx_valid, .rx_ready, .cab_operating);
    lit_peer peer (.go, .cab_rx_data, .cab_rx_clk, .loc_rx_data,
        .loc_rx_clk);
    // The clock, 10 ns period.
    always #5 ref_clk = ~ref_clk;
    // Monitors read pre-edge values, so each sample is the settled one.
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (!rst && cab_tx_data !== LIT_TRAIN_SYM) begin
            txq.push_back(cab_tx_data);
            txt.push_back(cyc);
        end
        if (loc_tx_valid === 1'b1 && loc_tx_data !== LIT_TRAIN_SYM)
            locq.push_back(loc_tx_data);
        if (rx_valid === 1'b1 && rx_ready === 1'b1)
            flq.push_back(rx_flit);
        if (tx_valid === 1'b1 && tx_ready === 1'b0)
            full_seen = 1'b1;
        loc_clk_q <= loc_tx_clk;
        // The local chip samples only on the forwarded clock's edges.
        if (!rst && loc_tx_clk !== loc_clk_q) begin
            n_loc_clk <= n_loc_clk + 1;
            check(36'(loc_tx_valid), 36'h1);
        end
    end
    task automatic check(input logic [35:0] got, input logic [35:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Holds the word until an edge samples ready high; leaves valid up.
    task automatic put(input lit_flit_t f);
        int n;
        n = 0;
        tx_flit = f;
        tx_valid = 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (tx_ready !== 1'b1 && n < 50);
        t_take = cyc;
        #1;
    endtask
    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // A hang is cut short well beyond the few hundred cycles needed.
    initial begin
        #50us;
        failures++;
        report_and_stop();
    end
    // Reset, the row loop, then the awkward cases.
    initial begin
        wait_cyc(4);
        rst = 1'b0;
        check(36'(cab_tx_data), 36'(LIT_TRAIN_SYM));
        check(36'(tx_ready), 36'h1);
        check(36'({cab_operating, loc_tx_valid, rx_valid}), 36'h0);
        foreach (rows[r]) begin
            txq.delete();
            txt.delete();
            put(rows[r].flit);
            tx_valid = 1'b0;
            wait_cyc(20);
            check(36'(txq.size()), 36'h4);
            // The monitor logs a byte one edge after the edge driving it.
            check(36'(txt[0] - t_take), 36'(LIT_SER_LAT + 1));
            foreach (txq[k]) begin
                exp_sym = k ? rows[r].flit.data[k] : rows[r].first;
                check(36'(txq[k]), 36'(exp_sym));
                check(36'(txt[k] - txt[0]), 36'(k));
            end
        end
        // Four words back to back: the fourth must be held off a while.
        txq.delete();
        txt.delete();
        foreach (rows[r]) put(rows[r].flit);
        tx_valid = 1'b0;
        wait_cyc(60);
        check(36'(full_seen), 36'h1);
        check(36'(txq.size()), 36'd16);
        foreach (txq[k]) begin
            exp_sym = rows[k / 4].flit.data[k % 4];
            check(36'(txq[k]), 36'(exp_sym));
        end
        // Cable training with the local side stalled meanwhile.
        go = 1'b1;
        for (int n = 0; n < 400 && cab_operating !== 1'b1; n++)
            wait_cyc(1);
        check(36'(cab_operating), 36'h1);
        wait_cyc(200);
        check(36'(locq.size()), 36'h4);
        foreach (locq[k]) check(36'(locq[k]), 36'(9'h0B8 + k));
        check(36'(n_loc_clk), 36'd8);
        check(36'(rx_valid), 36'h1);
        rx_ready = 1'b1;
        wait_cyc(10);
        check(36'(flq.size()), 36'h2);
        foreach (flq[k])
            for (int m = 0; m < 4; m++)
                check(36'(flq[k].data[m]), 36'(9'h101 + 4 * k + m));
        report_and_stop();
    end
endmodule
